// file: rtl/ufd_uart.v
// Three-channel asynchronous serial port with FIFOs and flow control
// Overview of operation
// - Three independent channels, each using interrupt or DMA requests.
// - Each channel has its own 16-byte receive and transmit FIFO.
// - Frame: start, five to eight data, optional parity, one or two stops.
// - Break waits for current word, sends one low frame, then resumes.
// - Data flows FIFO to shifter to pin, and pin to shifter to FIFO.
// - Overrun flagged when a new character overwrites an unread one.
// - Frame error flagged when a stop bit is not high.
// - FIFO mode: three idle word times with data waiting give time-out.
// - Only channels 0 and 1 have handshake lines and automatic control.
// - Automatic control starts a character only while clear-to-send is active; a break frame starts here regardless of it.
// - Request-to-send on above two free bytes, off below one free byte.
// - Status shows overrun, frame error, data ready, tx empties.
// - Errors raise error request only when its enable is set.
// - FIFO mode: Rx request when occupancy reaches Rx trigger level.
// - Non-FIFO mode: each received character raises Rx request; here one that overruns an unread one raises none.
// - FIFO mode: Tx request when remaining count falls to trigger.
// - Non-FIFO mode: each holding-to-shifter move raises Tx request.
// - DMA mode issues a DMA request instead of Rx or Tx request.
// - FIFO mode: error request on frame error or full-FIFO overrun.
// - Non-FIFO mode: all errors, simultaneous ones give one request.
// - Error shown when faulty character reaches read position.
// - Bit clock is source divided by divisor plus one, then by 16.
// - Word length 00..11 selects five to eight data bits.
// - Loopback routes the transmit output into the own receiver.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "ufd_defs.vh"

module ufd_uart #(
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // Serial lines
  input  wire        external_serial_clock,
  input  wire [2:0]  serial_rx_pin,
  output wire [2:0]  serial_tx_pin,
  input  wire [1:0]  clear_to_send_in_n,
  output wire [1:0]  request_to_send_out_n,
  // Requests per channel
  output wire [2:0]  rx_irq,
  output wire [2:0]  tx_irq,
  output wire [2:0]  err_irq,
  output wire [2:0]  channel_dma_request
);

  localparam [PW:0]   FULL   = DEPTH;
  localparam [PW:0]   RTS_ON = DEPTH - 2;
  localparam [PW:0]   ONE    = 1;
  localparam [PW:0]   ZERO   = 0;
  localparam [PW-1:0] PONE   = 1;

  //--------------------------------------------------------------------
  // Frame helpers
  //--------------------------------------------------------------------
  function [3:0] flen;
    input [6:0] lc;
    begin
      flen = 4'h7 + {2'h0, lc[1:0]} + {3'h0, lc[5]} + {3'h0, lc[2]};
    end
  endfunction

  function [7:0] dmask;
    input [1:0] wl;
    begin
      dmask = 8'hFF >> (2'h3 - wl);
    end
  endfunction

  function [11:0] txframe;
    input [7:0] d;
    input [6:0] lc;
    integer   i;
    reg [3:0] dl;
    reg       p;
    begin
      dl = 4'h5 + {2'h0, lc[1:0]};
      txframe = 12'hFFE;
      p = ^(d & dmask(lc[1:0]));
      for (i = 0; i < 8; i = i + 1) begin
        if (i < dl)
          txframe[i + 1] = d[i];
      end
      if (lc[5])
        txframe[dl + 4'h1] = lc[4] ? ~lc[3] : (p ^ ~lc[3]);
    end
  endfunction

  //--------------------------------------------------------------------
  // External clock edge
  //--------------------------------------------------------------------
  reg  es1_q;
  reg  es2_q;
  reg  es3_q;
  wire ext_tick = es2_q & ~es3_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      es1_q <= 1'b0;
      es2_q <= 1'b0;
      es3_q <= 1'b0;
    end else begin
      es1_q <= external_serial_clock;
      es2_q <= es1_q;
      es3_q <= es2_q;
    end
  end

  wire [95:0] rd_all;
  wire [2:0]  cts_n_all = {1'b1, clear_to_send_in_n};
  wire [2:0]  rts_n_all;
  assign request_to_send_out_n = rts_n_all[1:0];

  //--------------------------------------------------------------------
  // Channels
  //--------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ch
      reg  [6:0]    lcon_q;
      reg  [7:0]    ucon_q;
      reg  [7:0]    fcon_q;
      reg  [4:0]    mcon_q;
      reg  [15:0]   div_q;
      reg  [15:0]   dcnt_q;
      reg  [7:0]    tmem [0:DEPTH-1];
      reg  [PW-1:0] twp_q;
      reg  [PW-1:0] trp_q;
      reg  [PW:0]   tcnt_q;
      reg           tbusy_q;
      reg           tbrk_q;
      reg  [11:0]   tsh_q;
      reg  [3:0]    tbit_q;
      reg  [3:0]    ttk_q;
      reg           txo_q;
      reg  [7:0]    rmem [0:DEPTH-1];
      reg  [DEPTH-1:0] rfe_q;
      reg  [DEPTH-1:0] rov_q;
      reg  [PW-1:0] rwp_q;
      reg  [PW-1:0] rrp_q;
      reg  [PW:0]   rcnt_q;
      reg           ract_q;
      reg           rarm_q;
      reg           rdone_q;
      reg  [11:0]   rsh_q;
      reg  [3:0]    rbit_q;
      reg  [3:0]    rtk_q;
      reg  [1:0]    estat_q;
      reg  [1:0]    rep_q;
      reg  [9:0]    tocnt_q;
      reg           tofired_q;
      reg           rts_n_q;
      reg           rxi_q;
      reg           txi_q;
      reg           eri_q;
      reg           dma_q;
      reg  [31:0]   rdv;

      wire          sel   = (reg_addr[7:6] == c);
      wire [3:0]    idx   = reg_addr[5:2];
      wire          wr    = reg_wr & sel;
      wire          fen   = fcon_q[`UFD_F_EN];
      wire          ahs   = (c < 2) & mcon_q[`UFD_M_AUTO];
      wire          cts   = ~cts_n_all[c];
      wire [3:0]    len   = flen(lcon_q);
      wire          src   = ucon_q[`UFD_C_CLKSEL] ? ext_tick : 1'b1;
      wire          tick  = src & (dcnt_q == div_q);
      wire          fwr   = wr & (idx == `UFD_R_FCTRL);
      wire          rxrst = fwr & reg_wdata[`UFD_F_RXRST];
      wire          txrst = fwr & reg_wdata[`UFD_F_TXRST];
      // Non-FIFO mode behaves as a one-entry holding register
      wire          tfull = fen ? (tcnt_q == FULL) : |tcnt_q;
      wire          rfull = fen ? (rcnt_q == FULL) : |rcnt_q;
      wire          tpush = wr & (idx == `UFD_R_TXD) & ~tfull;
      wire          bstart = ~tbusy_q & ucon_q[`UFD_C_BRK];
      wire          tstart = ~tbusy_q & ~ucon_q[`UFD_C_BRK] & |tcnt_q
                             & (~ahs | cts);
      wire          rin   = ucon_q[`UFD_C_LOOP] ? txo_q
                            : serial_rx_pin[c];
      wire          rpop  = reg_rd & sel & (idx == `UFD_R_RXD) & |rcnt_q;
      wire          esrd  = reg_rd & sel & (idx == `UFD_R_ESTAT);
      wire          rpush = rdone_q & ~rfull;
      wire          rovr  = rdone_q & rfull;
      wire [PW-1:0] rlast = rwp_q - PONE;
      wire [7:0]    rdat  = rsh_q[8:1] & dmask(lcon_q[1:0]);
      wire          rbad  = ~rsh_q[len - 4'h1]
                            | (lcon_q[2] & ~rsh_q[len - 4'h2]);
      wire [1:0]    hd    = {rfe_q[rrp_q], rov_q[rrp_q]} & {2{|rcnt_q}};
      wire [1:0]    newe  = hd & ~rep_q;
      wire [PW:0]   rtrig = {{1'b0, fcon_q[5:4]} + 3'h1, 2'h0};
      wire [PW:0]   ttrig = {1'b0, fcon_q[7:6], 2'h0};
      wire [9:0]    tolim = `UFD_TO_WORDS * {2'h0, len, 4'h0};
      wire          toev  = fen & ~tofired_q & |rcnt_q
                            & (tocnt_q == tolim);
      wire          rxev  = (rpush & (~fen | (rcnt_q + ONE == rtrig)))
                            | toev;
      wire          txev  = tstart & (~fen | (tcnt_q - ONE == ttrig));

      //----------------------------------------------------------------
      // Channel state
      //----------------------------------------------------------------
      always @(posedge clk) begin
        if (sys_rst) begin
          lcon_q    <= `UFD_RST_LINE;
          ucon_q    <= `UFD_RST_CTRL;
          fcon_q    <= `UFD_RST_FCTL;
          mcon_q    <= `UFD_RST_MCTL;
          div_q     <= `UFD_RST_DIV;
          dcnt_q    <= 16'h0000;
          twp_q     <= {PW{1'b0}};
          trp_q     <= {PW{1'b0}};
          tcnt_q    <= ZERO;
          tbusy_q   <= 1'b0;
          tbrk_q    <= 1'b0;
          tsh_q     <= 12'hFFF;
          tbit_q    <= 4'h0;
          ttk_q     <= 4'h0;
          txo_q     <= 1'b1;
          rwp_q     <= {PW{1'b0}};
          rrp_q     <= {PW{1'b0}};
          rcnt_q    <= ZERO;
          rfe_q     <= {DEPTH{1'b0}};
          rov_q     <= {DEPTH{1'b0}};
          ract_q    <= 1'b0;
          rarm_q    <= 1'b0;
          rdone_q   <= 1'b0;
          rsh_q     <= 12'h000;
          rbit_q    <= 4'h0;
          rtk_q     <= 4'h0;
          estat_q   <= 2'h0;
          rep_q     <= 2'h0;
          tocnt_q   <= 10'h000;
          tofired_q <= 1'b0;
          rts_n_q   <= 1'b1;
          rxi_q     <= 1'b0;
          txi_q     <= 1'b0;
          eri_q     <= 1'b0;
          dma_q     <= 1'b0;
        end else begin
          if (src)
            dcnt_q <= (dcnt_q == div_q) ? 16'h0000 : dcnt_q + 16'h0001;
          // Transmit FIFO and shifter
          if (tpush) begin
            tmem[twp_q] <= reg_wdata[7:0];
            twp_q       <= twp_q + PONE;
          end
          if (tstart)
            trp_q <= trp_q + PONE;
          tcnt_q <= tcnt_q + (tpush ? ONE : ZERO) - (tstart ? ONE : ZERO);
          if (tstart | bstart) begin
            tbusy_q <= 1'b1;
            tbrk_q  <= bstart;
            tbit_q  <= 4'h0;
            ttk_q   <= 4'h0;
            tsh_q   <= bstart ? 12'h000 : txframe(tmem[trp_q], lcon_q);
          end else if (tick & tbusy_q) begin
            ttk_q <= ttk_q + 4'h1;
            if (ttk_q == `UFD_OVS_LAST) begin
              tsh_q  <= {1'b1, tsh_q[11:1]};
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q == len - 4'h1) begin
                tbusy_q <= 1'b0;
                if (tbrk_q)
                  ucon_q[`UFD_C_BRK] <= 1'b0;
              end
            end
          end
          txo_q <= ~tbusy_q | tsh_q[0];
          if (txrst) begin
            twp_q  <= {PW{1'b0}};
            trp_q  <= {PW{1'b0}};
            tcnt_q <= ZERO;
          end
          // Receive shifter
          rdone_q <= 1'b0;
          if (tick) begin
            if (!ract_q) begin
              if (rin) begin
                rarm_q <= 1'b1;
              end else if (rarm_q) begin
                ract_q <= 1'b1;
                rarm_q <= 1'b0;
                rtk_q  <= 4'h0;
                rbit_q <= 4'h0;
              end
            end else begin
              rtk_q <= rtk_q + 4'h1;
              if (rtk_q == `UFD_MID) begin
                rsh_q[rbit_q] <= rin;
                rbit_q        <= rbit_q + 4'h1;
                if ((rbit_q == 4'h0) & rin) begin
                  ract_q <= 1'b0;
                end else if (rbit_q == len - 4'h1) begin
                  ract_q  <= 1'b0;
                  rdone_q <= 1'b1;
                end
              end
            end
          end
          // Receive FIFO with error bits
          if (rpush) begin
            rmem[rwp_q]  <= rdat;
            rfe_q[rwp_q] <= rbad;
            rov_q[rwp_q] <= 1'b0;
            rwp_q        <= rwp_q + PONE;
          end
          if (rovr) begin
            rmem[rlast]  <= rdat;
            rfe_q[rlast] <= rbad;
            rov_q[rlast] <= 1'b1;
          end
          if (rpop)
            rrp_q <= rrp_q + PONE;
          rcnt_q <= rcnt_q + (rpush ? ONE : ZERO) - (rpop ? ONE : ZERO);
          if (rxrst) begin
            rwp_q  <= {PW{1'b0}};
            rrp_q  <= {PW{1'b0}};
            rcnt_q <= ZERO;
          end
          // Error reporting at the read position
          rep_q   <= rpop ? 2'h0 : (rep_q | newe);
          eri_q   <= |newe & ucon_q[`UFD_C_EIE];
          estat_q <= esrd ? newe : (estat_q | newe);
          // Receive time-out
          if (rpush | rpop | ~fen | ~|rcnt_q) begin
            tocnt_q   <= 10'h000;
            tofired_q <= 1'b0;
          end else if (toev) begin
            tofired_q <= 1'b1;
          end else if (tick) begin
            tocnt_q <= tocnt_q + 10'h001;
          end
          // Request-to-send
          if (ahs) begin
            if (rcnt_q < RTS_ON)
              rts_n_q <= 1'b0;
            else if (rcnt_q == FULL)
              rts_n_q <= 1'b1;
          end else begin
            rts_n_q <= ~mcon_q[`UFD_M_RTS];
          end
          // Requests
          rxi_q <= rxev & (ucon_q[1:0] == `UFD_MODE_IRQ);
          txi_q <= txev & (ucon_q[3:2] == `UFD_MODE_IRQ);
          dma_q <= (rxev & (ucon_q[1:0] == `UFD_MODE_DMA))
                   | (txev & (ucon_q[3:2] == `UFD_MODE_DMA));
          // Register writes
          if (wr) begin
            case (idx)
              `UFD_R_LINE:  lcon_q <= reg_wdata[6:0];
              `UFD_R_CTRL:  ucon_q <= reg_wdata[7:0];
              `UFD_R_FCTRL: fcon_q <= {reg_wdata[7:3], 2'h0, reg_wdata[0]};
              `UFD_R_MCTRL: mcon_q <= reg_wdata[4:0];
              `UFD_R_DIV:   div_q  <= reg_wdata[15:0];
              default: ;
            endcase
          end
        end
      end

      //----------------------------------------------------------------
      // Read view
      //----------------------------------------------------------------
      always @* begin
        rdv = 32'h0000_0000;
        case (idx)
          `UFD_R_LINE:   rdv = {25'h000_0000, lcon_q};
          `UFD_R_CTRL:   rdv = {24'h00_0000, ucon_q};
          `UFD_R_FCTRL:  rdv = {24'h00_0000, fcon_q};
          `UFD_R_MCTRL:  rdv = {27'h000_0000, mcon_q};
          `UFD_R_TRSTAT: rdv = {29'h0000_0000, ~|tcnt_q & ~tbusy_q,
                                ~|tcnt_q, |rcnt_q};
          `UFD_R_ESTAT:  rdv = {30'h0000_0000, estat_q};
          `UFD_R_FSTAT:  rdv = {19'h0_0000, tcnt_q, 3'h0, rcnt_q};
          `UFD_R_MSTAT:  rdv = {31'h0000_0000, cts};
          `UFD_R_RXD:    rdv = {24'h00_0000, rmem[rrp_q]};
          `UFD_R_DIV:    rdv = {16'h0000, div_q};
          default:       rdv = 32'h0000_0000;
        endcase
      end

      assign rd_all[32*c +: 32]     = rdv;
      assign serial_tx_pin[c]       = txo_q;
      assign rts_n_all[c]           = rts_n_q;
      assign rx_irq[c]              = rxi_q;
      assign tx_irq[c]              = txi_q;
      assign err_irq[c]             = eri_q;
      assign channel_dma_request[c] = dma_q;
    end
  endgenerate

  //--------------------------------------------------------------------
  // Read data, one cycle after the strobe
  //--------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata_q <= 32'h0000_0000;
    else if (reg_rd & (reg_addr[7:6] != `UFD_CH_NONE))
      reg_rdata_q <= rd_all[{reg_addr[7:6], 5'h00} +: 32];
    else
      reg_rdata_q <= 32'h0000_0000;
  end

endmodule // ufd_uart

// file: rtl/ufd_defs.vh
// Register indices, field positions and reset values of the serial port
`ifndef UFD_DEFS_VH
`define UFD_DEFS_VH

//----------------------------------------------------------------------
// Register indices (address bits 5:2 within a channel)
//----------------------------------------------------------------------
`define UFD_R_LINE   4'h0
`define UFD_R_CTRL   4'h1
`define UFD_R_FCTRL  4'h2
`define UFD_R_MCTRL  4'h3
`define UFD_R_TRSTAT 4'h4
`define UFD_R_ESTAT  4'h5
`define UFD_R_FSTAT  4'h6
`define UFD_R_MSTAT  4'h7
`define UFD_R_TXD    4'h8
`define UFD_R_RXD    4'h9
`define UFD_R_DIV    4'hA
`define UFD_CH_NONE  2'h3

//----------------------------------------------------------------------
// Field positions
//----------------------------------------------------------------------
`define UFD_C_BRK    4
`define UFD_C_LOOP   5
`define UFD_C_EIE    6
`define UFD_C_CLKSEL 7
`define UFD_F_EN     0
`define UFD_F_RXRST  1
`define UFD_F_TXRST  2
`define UFD_M_RTS    0
`define UFD_M_AUTO   4

//----------------------------------------------------------------------
// Modes, timing and reset values
//----------------------------------------------------------------------
`define UFD_MODE_IRQ 2'h1
`define UFD_MODE_DMA 2'h2
`define UFD_OVS_LAST 4'hF
`define UFD_MID      4'h7
`define UFD_TO_WORDS 10'h003
`define UFD_RST_LINE 7'h00
`define UFD_RST_CTRL 8'h00
`define UFD_RST_FCTL 8'h00
`define UFD_RST_MCTL 5'h00
`define UFD_RST_DIV  16'h0000

`endif

// file: verif/ufd_partner.sv
// Far-end serial device model on channel 0
`timescale 1ns/10ps
module ufd_partner (
  // Clock
  input  wire        clk,
  // Serial lines
  input  wire        tx_line,
  output logic       rx_line,
  input  wire        ready,
  output wire        cts_n,
  // Received characters
  output logic [7:0] got,
  output int         got_n
);
  localparam int BT = 16;

  // Clear-to-send only while the ready input is high
  assign cts_n = !ready;

  // Eight data bits, no parity, stop as given, then one idle bit
  task automatic send(input logic [7:0] d, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BT) @(posedge clk);
    end
  endtask

  initial begin
    rx_line = 1'b1;
    got     = 8'h00;
    got_n   = 0;
    forever begin
      @(negedge tx_line);
      repeat (BT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BT) @(posedge clk);
        got[i] = tx_line;
      end
      repeat (BT) @(posedge clk);
      got_n++;
    end
  end
endmodule // ufd_partner

// file: verif/ufd_uart_properties.sv
// Port-level checks of the serial port
`timescale 1ns/10ps
module ufd_checker (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Register port
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  // Serial lines and requests
  input wire [2:0]  serial_tx_pin,
  input wire [1:0]  request_to_send_out_n,
  input wire [2:0]  rx_irq,
  input wire [2:0]  tx_irq,
  input wire [2:0]  err_irq,
  input wire [2:0]  channel_dma_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence start_low;
    !serial_tx_pin[0] [*8];
  endsequence

  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata_q == 32'h0000_0000) else $error("rdata not idle");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr[7:6] == 2'h3 |=> reg_rdata_q == 32'h0000_0000)
    else $error("unmapped channel read not zero");
  chk_rx_pulse: assert property (
    |rx_irq |=> (rx_irq & $past(rx_irq)) == 3'h0) else $error("rx long");
  chk_tx_pulse: assert property (
    |tx_irq |=> (tx_irq & $past(tx_irq)) == 3'h0) else $error("tx long");
  chk_err_single: assert property (
    |err_irq |=> (err_irq & $past(err_irq)) == 3'h0) else $error("err long");
  chk_dma_pulse: assert property (
    |channel_dma_request |=> (channel_dma_request
      & $past(channel_dma_request)) == 3'h0) else $error("dma long");
  chk_start_len: assert property (
    $fell(serial_tx_pin[0]) |-> start_low) else $error("start too short");
  chk_tx_irq_start: assert property (
    tx_irq[0] |=> !serial_tx_pin[0]) else $error("tx request off start");
  chk_reset_idle: assert property (
    $fell(sys_rst) |-> serial_tx_pin == 3'h7
      && request_to_send_out_n == 2'h3) else $error("lines not idle");
endmodule // ufd_checker

bind ufd_uart ufd_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .serial_tx_pin(serial_tx_pin),
  .request_to_send_out_n(request_to_send_out_n), .rx_irq(rx_irq),
  .tx_irq(tx_irq), .err_irq(err_irq),
  .channel_dma_request(channel_dma_request)
);

// file: verif/uart_fifo_flow_irq_dma_bench.sv
// Self-checking bench of the three-channel serial port
`timescale 1ns/10ps
`include "ufd_defs.vh"
module uart_fifo_flow_irq_dma_bench;
  logic        clk, sys_rst, reg_wr, reg_rd, ready;
  logic [7:0]  reg_addr, b;
  logic [31:0] reg_wdata, v, seed;
  wire  [31:0] reg_rdata_q;
  wire  [2:0]  serial_tx_pin, rx_irq, tx_irq, err_irq, channel_dma_request;
  wire  [1:0]  request_to_send_out_n;
  wire         p_rx, p_cts_n;
  wire  [7:0]  got;
  int          got_n, errors, check_count, n, e0, g0;
  int          ev_n = 0;
  int          err_n = 0;
  int          tx_n = 0;
  logic        ext_clk = 1'b0;
  byte unsigned exp_q[$];

  ufd_uart dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .external_serial_clock(ext_clk),
    .serial_rx_pin({2'b11, p_rx}), .serial_tx_pin(serial_tx_pin),
    .clear_to_send_in_n({1'b1, p_cts_n}),
    .request_to_send_out_n(request_to_send_out_n), .rx_irq(rx_irq),
    .tx_irq(tx_irq), .err_irq(err_irq),
    .channel_dma_request(channel_dma_request));

  ufd_partner p (
    .clk(clk), .tx_line(serial_tx_pin[0]), .rx_line(p_rx), .ready(ready),
    .cts_n(p_cts_n), .got(got), .got_n(got_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    ev_n  <= ev_n + $countones({rx_irq, channel_dma_request});
    err_n <= err_n + err_irq[0];
    tx_n  <= tx_n + $countones(tx_irq);
    ext_clk <= ~ext_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] ch, input logic [3:0] idx,
                    input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= {ch, idx, 2'b00};
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] ch, input logic [3:0] idx);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= {ch, idx, 2'b00};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask

  task automatic rx_chk(input logic [1:0] ch);
    rd(ch, `UFD_R_RXD);
    chk(v & 32'h0000_00FF, 32'(exp_q.pop_front()));
  endtask

  task automatic send(input logic [7:0] d, input logic stp);
    exp_q.push_back(d);
    p.send(d, stp);
  endtask

  // Bounded wait for a receive request or DMA pulse
  task automatic wait_ev(input int want, input int lim);
    for (n = 0; n < lim && ev_n < want; n++) @(posedge clk);
    chk(32'(n < lim), 32'h0000_0001);
  endtask

  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    print_verdict();
  end

  initial begin
    seed = 32'h0000_0053;
    errors = 0;
    check_count = 0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ready} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    //------------------------------------------------------------------
    // Reset values and address map
    //------------------------------------------------------------------
    rd(0, `UFD_R_LINE); chk(v, 32'(`UFD_RST_LINE));
    rd(1, `UFD_R_CTRL); chk(v, 32'(`UFD_RST_CTRL));
    rd(2, `UFD_R_TRSTAT); chk(v, 32'h0000_0006);
    rd(2, `UFD_R_MSTAT); chk(v, 32'h0000_0000);
    b = 8'(xs());
    wr(1, `UFD_R_DIV, {16'h0000, b, ~b});
    rd(1, `UFD_R_DIV); chk(v, {16'h0000, b, ~b});
    // Mid-run reset also returns the divisor register to its reset value
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(1, `UFD_R_DIV); chk(v, 32'(`UFD_RST_DIV));
    wr(3, `UFD_R_LINE, 32'h0000_00FF);
    rd(3, `UFD_R_LINE); chk(v, 32'h0000_0000);
    //------------------------------------------------------------------
    // Loopback on every channel and word length, irq and DMA
    //------------------------------------------------------------------
    for (int ch = 0; ch < 3; ch++)
      for (int wl = 0; wl < 4; wl++) begin
        wr(2'(ch), `UFD_R_LINE, 32'(wl));
        wr(2'(ch), `UFD_R_CTRL, 32'h0000_0024 + (wl[0] ? 32'h2 : 32'h1)
           + (ch == 2 ? 32'h80 : 32'h0));
        b = 8'(xs()) & 8'((1 << (wl + 5)) - 1);
        exp_q.push_back(b);
        e0 = ev_n;
        g0 = tx_n;
        wr(2'(ch), `UFD_R_TXD, 32'(b));
        wait_ev(e0 + 1, 2000);
        rx_chk(2'(ch));
        chk(32'(tx_n - g0), 32'h0000_0001);
      end
    //------------------------------------------------------------------
    // Channel 0 FIFO trigger, time-out, frame error, overrun
    //------------------------------------------------------------------
    wr(0, `UFD_R_CTRL, 32'h0000_0041);
    wr(0, `UFD_R_FCTRL, 32'h0000_0001);
    e0 = ev_n;
    for (int i = 0; i < 3; i++) send(8'(xs()), 1'b1);
    chk(32'(ev_n - e0), 32'h0000_0000);
    send(8'(xs()), 1'b1);
    chk(32'(ev_n - e0), 32'h0000_0001);
    rd(0, `UFD_R_FSTAT); chk(v & 32'h0000_001F, 32'h0000_0004);
    for (int i = 0; i < 4; i++) rx_chk(0);
    e0 = ev_n;
    send(8'(xs()), 1'b1);
    wait_ev(e0 + 1, 1000);
    chk(32'(n > 440 && n < 480), 32'h0000_0001);
    rx_chk(0);
    e0 = err_n;
    send(8'(xs()), 1'b1);
    send(8'(xs()), 1'b0);
    chk(32'(err_n - e0), 32'h0000_0000);
    rx_chk(0);
    repeat (4) @(posedge clk);
    chk(32'(err_n - e0), 32'h0000_0001);
    rd(0, `UFD_R_ESTAT); chk(v & 32'h0000_0003, 32'h0000_0002);
    rd(0, `UFD_R_ESTAT); chk(v & 32'h0000_0003, 32'h0000_0000);
    rx_chk(0);
    wr(0, `UFD_R_FCTRL, 32'h0000_0000);
    e0 = err_n;
    send(8'(xs()), 1'b1);
    send(8'(xs()), 1'b1);
    void'(exp_q.pop_front());
    chk(32'(err_n - e0), 32'h0000_0001);
    rd(0, `UFD_R_ESTAT); chk(v & 32'h0000_0001, 32'h0000_0001);
    rx_chk(0);
    //------------------------------------------------------------------
    // Automatic and software flow control
    //------------------------------------------------------------------
    wr(0, `UFD_R_MCTRL, 32'h0000_0010);
    rd(0, `UFD_R_MSTAT); chk(v & 32'h0000_0001, 32'h0000_0000);
    chk(32'(request_to_send_out_n[0]), 32'h0000_0000);
    g0 = got_n;
    b = 8'(xs());
    wr(0, `UFD_R_TXD, 32'(b));
    repeat (300) @(posedge clk);
    chk(32'(got_n - g0), 32'h0000_0000);
    ready <= 1'b1;
    rd(0, `UFD_R_MSTAT); chk(v & 32'h0000_0001, 32'h0000_0001);
    for (n = 0; n < 600 && got_n == g0; n++) @(posedge clk);
    chk(32'(got_n - g0), 32'h0000_0001);
    chk({24'h00_0000, got}, 32'(b));
    for (int ch = 0; ch < 2; ch++) begin
      wr(2'(ch), `UFD_R_MCTRL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'(request_to_send_out_n[ch]), 32'h0000_0000);
      wr(2'(ch), `UFD_R_MCTRL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(32'(request_to_send_out_n[ch]), 32'h0000_0001);
    end
    print_verdict();
  end
endmodule // uart_fifo_flow_irq_dma_bench
